// ### design/usart_cmd_ctrl.sv
// command strobes, protected mode register and line control
//
// Function
// - disable beats enable in same write
// - status clear wipes the ten error flags
// - break starts after transmitter drains, once
// - break ends after character, then 12 marks
// - wait command clears flag, stalls counter
// - multidrop only: next character carries address
// - retry_limit_flag clear in card mode; nack clear
// - RTS low on assert, high on release
// - SPI master: chip select forced or released
// - LIN abort and wakeup pulses
// - mode writes ignored while locked
// - protocol field decodes ten line protocols
// - baud source: main, divide by eight, external
// - character 5 to 8 bits, or nine
// - check bit type field
// - stop bit count field
// - channel routing: normal, echo, local, remote
// - SPI idle clock level and edge phase
// - drive clock pin unless external source
// - SPI master waits for receive ready clear
// - count parity errors, limit NACKs, flag
// - invert data field both directions
// - 17-bit time-out counter per bit period
// - rearm restarts counter at once
`timescale 1ns/100ps
`include "usart_cmd_map.svh"
module usart_cmd_ctrl (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // line pins
  input  wire logic        i_rxd,
  input  wire logic        i_sck,
  output logic             o_txd,
  output logic             o_sck,
  output logic             o_sck_oe,
  output logic             o_rts_n,
  // transmitter and receiver side
  input  wire logic        i_tx_serial,
  input  wire logic        i_tx_data_bit,
  input  wire logic        i_rx_data_bit,
  input  wire logic        i_tx_idle,
  input  wire logic        i_tx_busy,
  input  wire logic        i_rx_ready,
  input  wire logic        i_rx_char,
  input  wire logic        i_bit_tick,
  input  wire logic        i_baud_clk,
  input  wire logic        i_thr_write,
  input  wire logic [9:0]  i_err_events,
  input  wire logic        i_iso_par_err,
  input  wire logic        i_iso_char_ok,
  input  wire logic        i_nack_rx,
  // control to transmitter and receiver
  output logic             o_rx_en,
  output logic             o_tx_en,
  output logic             o_rx_reset,
  output logic             o_tx_reset,
  output logic             o_tx_go,
  output logic             o_addr_bit,
  output logic             o_nack_send,
  output logic             o_lin_abort,
  output logic             o_lin_wake,
  output logic             o_timeout,
  output logic             o_rx_line,
  output logic             o_baud_en,
  // decoded mode
  output logic      [3:0]  o_protocol,
  output logic      [3:0]  o_char_bits,
  output logic      [2:0]  o_parity,
  output logic      [1:0]  o_stop_bits,
  output logic             o_sync_spi_edge_phase,
  output logic             o_spi_idle_level_bit_order_sel,
  output logic             o_over8,
  output logic             o_invert
);

  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  usart_cmd_pkg::core_t st_reg;
  usart_cmd_pkg::core_t st_next;
  logic        rxd_s;
  logic        sck_s;
  logic [31:0] cmd;
  logic        mode_wr;
  logic        is_spim;

  function automatic logic [3:0] char_bits_f(input logic [31:0] m);
    if (m[`M_NINE]) begin
      char_bits_f = 4'h9;
    end else begin
      char_bits_f = 4'h5 + {2'h0, m[`M_CHAR_LEN_SEL]};
    end
  endfunction

  usart_in_sync u_rxd_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_pin     (i_rxd),
    .o_level   (rxd_s)
  );

  usart_in_sync u_sck_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_pin     (i_sck),
    .o_level   (sck_s)
  );

  assign cmd = (i_wr && i_addr == `OFS_CMD) ? i_wdata : 32'h0000_0000;
  assign mode_wr = i_wr && i_addr == `OFS_MODE && !st_reg.lock;
  assign is_spim = st_reg.mode[`M_PROTO] == usart_cmd_pkg::P_SPI_MST;

  // ----------------------------------------------------------------
  // next state; clears come first so a same-cycle event wins
  // ----------------------------------------------------------------
  always_comb begin
    logic        tx_line;
    logic        rx_src;
    logic [31:0] stat;
    tx_line = 1'b1;
    rx_src  = 1'b1;
    stat    = 32'h0000_0000;
    st_next = st_reg;
    st_next.rx_rst    = cmd[`C_RX_RST];
    st_next.tx_rst    = cmd[`C_TX_RST];
    st_next.lin_abort = cmd[`C_LIN_ABT];
    st_next.lin_wake  = cmd[`C_LIN_WAKE];
    st_next.nack_send = 1'b0;
    // direction enables
    if (cmd[`C_RX_DIS]) begin
      st_next.rx_en = 1'b0;
    end else if (cmd[`C_RX_EN]) begin
      st_next.rx_en = 1'b1;
    end
    if (cmd[`C_TX_DIS]) begin
      st_next.tx_en = 1'b0;
    end else if (cmd[`C_TX_EN]) begin
      st_next.tx_en = 1'b1;
    end
    // configuration; the time-out value shares the mode protection
    if (mode_wr) begin
      st_next.mode = i_wdata & `MODE_WMASK;
    end
    if (i_wr && i_addr == `OFS_LOCK) begin
      st_next.lock = i_wdata[0];
    end
    if (i_wr && i_addr == `OFS_TOVAL && !st_reg.lock) begin
      st_next.to_val = i_wdata[16:0];
    end
    st_next.char_bits = char_bits_f(st_next.mode);
    // error flags
    if (cmd[`C_STAT_CLR]) begin
      st_next.err = 10'h000;
    end
    if (cmd[`C_RX_RST]) begin
      st_next.err = st_next.err & `ERR_TX_MASK;
      st_next.to_flag = 1'b0;
      st_next.to_st = usart_cmd_pkg::T_WAIT;
      st_next.iter_cnt = 3'h0;
    end
    if (cmd[`C_TX_RST]) begin
      st_next.err = st_next.err & ~`ERR_TX_MASK;
      st_next.brk_st = usart_cmd_pkg::B_IDLE;
      st_next.addr_pend = 1'b0;
    end
    st_next.err = st_next.err | i_err_events;
    // non-acknowledge and iterations
    if (cmd[`C_NACK_CLR]) begin
      st_next.nack = 1'b0;
    end
    if (i_nack_rx) begin
      st_next.nack = 1'b1;
    end
    if (cmd[`C_ITER_RST] &&
        (st_reg.mode[`M_PROTO] == usart_cmd_pkg::P_ISO_T0 ||
         st_reg.mode[`M_PROTO] == usart_cmd_pkg::P_ISO_T1)) begin
      st_next.retry = 1'b0;
      st_next.iter_cnt = 3'h0;
    end
    if (i_iso_char_ok) begin
      st_next.iter_cnt = 3'h0;
    end
    if (i_iso_par_err) begin
      if (!st_reg.mode[`M_REPEAT_NACK_LIMIT]) begin
        st_next.nack_send = !st_reg.mode[`M_NACK_INHIBIT];
      end else if (st_reg.iter_cnt < st_reg.mode[`M_MAXIT]) begin
        st_next.nack_send = 1'b1;
        st_next.iter_cnt = st_reg.iter_cnt + 3'h1;
      end else begin
        st_next.retry = 1'b1;
      end
    end
    // address bit for the next character; a same-cycle command wins
    if (i_thr_write) begin
      st_next.addr_pend = 1'b0;
    end
    if (cmd[`C_SEND_ADDR] && st_reg.mode[`M_PAR] == `PAR_MULTI) begin
      st_next.addr_pend = 1'b1;
    end
    // the same two strobes drive RTS or the SPI chip select
    if (is_spim) begin
      if (cmd[`C_RTS_ON]) begin
        st_next.cs_force = 1'b1;
      end
      if (cmd[`C_RTS_OFF]) begin
        st_next.cs_force = 1'b0;
      end
    end else begin
      if (cmd[`C_RTS_ON]) begin
        st_next.rts_lvl = 1'b0;
      end
      if (cmd[`C_RTS_OFF]) begin
        st_next.rts_lvl = 1'b1;
      end
    end
    st_next.rts_n = is_spim ? !(st_next.cs_force || i_tx_busy)
                            : st_next.rts_lvl;
    // break sequence
    case (st_reg.brk_st)
      usart_cmd_pkg::B_IDLE: begin
        if (cmd[`C_BRK_GO] && !cmd[`C_TX_RST]) begin
          st_next.brk_st = usart_cmd_pkg::B_WAIT;
        end
      end
      usart_cmd_pkg::B_WAIT: begin
        if (i_tx_idle && !cmd[`C_TX_RST]) begin
          st_next.brk_st = usart_cmd_pkg::B_LOW;
          st_next.bit_cnt = 4'h0;
        end
      end
      usart_cmd_pkg::B_LOW,
      usart_cmd_pkg::B_STOP: begin
        if (i_bit_tick && st_reg.bit_cnt != 4'hf) begin
          st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
        end
        if (cmd[`C_BRK_END] && !cmd[`C_TX_RST]) begin
          st_next.brk_st = usart_cmd_pkg::B_STOP;
        end
        if (st_reg.brk_st == usart_cmd_pkg::B_STOP && !cmd[`C_TX_RST] &&
            st_reg.bit_cnt >= st_reg.char_bits + `CHAR_XTRA) begin
          st_next.brk_st = usart_cmd_pkg::B_MARK;
          st_next.bit_cnt = 4'h0;
        end
      end
      usart_cmd_pkg::B_MARK: begin
        if (i_bit_tick && !cmd[`C_TX_RST]) begin
          if (st_reg.bit_cnt == `MARK_BITS - 4'h1) begin
            st_next.brk_st = usart_cmd_pkg::B_IDLE;
          end else begin
            st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
          end
        end
      end
      default: begin
        st_next.brk_st = usart_cmd_pkg::B_IDLE;
      end
    endcase
    // receiver time-out; a zero value keeps it silent
    if (cmd[`C_TO_WAIT]) begin
      st_next.to_flag = 1'b0;
      st_next.to_st = usart_cmd_pkg::T_WAIT;
    end
    if (cmd[`C_TO_REARM]) begin
      st_next.to_cnt = st_reg.to_val;
      st_next.to_st = usart_cmd_pkg::T_RUN;
    end else if (i_rx_char) begin
      st_next.to_cnt = st_reg.to_val;
      st_next.to_st = usart_cmd_pkg::T_RUN;
    end else if (st_reg.to_st == usart_cmd_pkg::T_RUN && i_bit_tick &&
                 st_reg.to_val != 17'h0_0000) begin
      if (st_reg.to_cnt <= 17'h0_0001) begin
        st_next.to_cnt = 17'h0_0000;
        st_next.to_flag = 1'b1;
        st_next.to_st = usart_cmd_pkg::T_WAIT;
      end else begin
        st_next.to_cnt = st_reg.to_cnt - 17'h0_0001;
      end
    end
    // baud enable: every cycle, every eighth, or external rising edge
    st_next.sck_prev = sck_s;
    st_next.div_cnt = st_reg.div_cnt + 3'h1;
    case (st_reg.mode[`M_CLKSRC])
      `CLK_MAIN: st_next.baud_en = 1'b1;
      `CLK_DIV:  st_next.baud_en = st_reg.div_cnt == `DIV_LAST;
      `CLK_EXT:  st_next.baud_en = sck_s && !st_reg.sck_prev;
      default:   st_next.baud_en = 1'b0;
    endcase
    // line routing; inversion touches only the data field
    if (st_reg.brk_st == usart_cmd_pkg::B_LOW ||
        st_reg.brk_st == usart_cmd_pkg::B_STOP) begin
      tx_line = 1'b0;
    end else if (st_reg.brk_st == usart_cmd_pkg::B_MARK) begin
      tx_line = 1'b1;
    end else begin
      tx_line = i_tx_serial ^ (st_reg.mode[`M_INV] & i_tx_data_bit);
    end
    case (st_reg.mode[`M_LOOP])
      usart_cmd_pkg::L_ECHO: begin
        st_next.txd = rxd_s;
        rx_src = rxd_s;
      end
      usart_cmd_pkg::L_LOCAL: begin
        st_next.txd = 1'b1;
        rx_src = tx_line;
      end
      usart_cmd_pkg::L_REMOTE: begin
        st_next.txd = rxd_s;
        rx_src = 1'b1;
      end
      default: begin
        st_next.txd = tx_line;
        rx_src = rxd_s;
      end
    endcase
    st_next.rx_line = rx_src ^ (st_reg.mode[`M_INV] & i_rx_data_bit);
    // serial clock pin
    st_next.sck_oe = st_reg.mode[`M_SERIAL_CLK_DRIVE] &&
                     st_reg.mode[`M_CLKSRC] != `CLK_EXT;
    if (st_reg.mode[3:1] == 3'h7) begin
      st_next.sck = i_tx_busy ? st_reg.mode[`M_SPI_IDLE_LEVEL] ^ i_baud_clk
                              : st_reg.mode[`M_SPI_IDLE_LEVEL];
    end else begin
      st_next.sck = i_baud_clk;
    end
    st_next.tx_go = st_next.tx_en &&
                    !(is_spim && st_reg.mode[`M_NACK_INHIBIT] && i_rx_ready);
    // read port: data only in the cycle after the strobe
    stat[`ST_RX_ENABLE_CMD] = st_reg.rx_en;
    stat[`ST_TX_ENABLE_CMD] = st_reg.tx_en;
    stat[`ST_BRK]  = st_reg.brk_st != usart_cmd_pkg::B_IDLE;
    stat[`ST_TO]   = st_reg.to_flag;
    stat[`ST_ITER] = st_reg.retry;
    stat[`ST_NACK] = st_reg.nack;
    stat[`ST_ADDR] = st_reg.addr_pend;
    stat[`ST_LOCK] = st_reg.lock;
    stat[`ST_ERR_LSB +: 10] = st_reg.err;
    st_next.rdata = 32'h0000_0000;
    if (i_rd) begin
      case (i_addr)
        `OFS_MODE:  st_next.rdata = st_reg.mode;
        `OFS_STAT:  st_next.rdata = stat;
        `OFS_LOCK:  st_next.rdata = {31'h0000_0000, st_reg.lock};
        `OFS_TOVAL: st_next.rdata = {15'h0000, st_reg.to_val};
        default:    st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_reg         <= '0;
      st_reg.mode    <= `MODE_RST;
      st_reg.to_val  <= `TOVAL_RST;
      st_reg.rts_lvl <= 1'b1;
      st_reg.rts_n   <= 1'b1;
      st_reg.txd     <= 1'b1;
      st_reg.rx_line <= 1'b1;
      // the clock synchroniser resets high; no false edge after reset
      st_reg.sck_prev <= 1'b1;
      st_reg.char_bits <= 4'h5;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_rdata     = st_reg.rdata;
  assign o_txd       = st_reg.txd;
  assign o_sck       = st_reg.sck;
  assign o_sck_oe    = st_reg.sck_oe;
  assign o_rts_n     = st_reg.rts_n;
  assign o_rx_en     = st_reg.rx_en;
  assign o_tx_en     = st_reg.tx_en;
  assign o_rx_reset  = st_reg.rx_rst;
  assign o_tx_reset  = st_reg.tx_rst;
  assign o_tx_go     = st_reg.tx_go;
  assign o_addr_bit  = st_reg.addr_pend;
  assign o_nack_send = st_reg.nack_send;
  assign o_lin_abort = st_reg.lin_abort;
  assign o_lin_wake  = st_reg.lin_wake;
  assign o_timeout   = st_reg.to_flag;
  assign o_rx_line   = st_reg.rx_line;
  assign o_baud_en   = st_reg.baud_en;
  assign o_protocol  = st_reg.mode[`M_PROTO];
  assign o_char_bits = st_reg.char_bits;
  assign o_parity    = st_reg.mode[`M_PAR];
  assign o_stop_bits = st_reg.mode[`M_STOP];
  assign o_sync_spi_edge_phase = st_reg.mode[`M_SPI_EDGE_PHASE];
  assign o_spi_idle_level_bit_order_sel = st_reg.mode[`M_SPI_IDLE_LEVEL];
  assign o_over8     = st_reg.mode[`M_OVER];
  assign o_invert    = st_reg.mode[`M_INV];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  tx_dis_a: assert property (
    cmd[`C_TX_DIS] |=> !o_tx_en && !o_tx_go)
    else $error("transmitter still enabled after disable");

  stat_clr_a: assert property (
    cmd[`C_STAT_CLR] && i_err_events == 10'h000 |=> st_reg.err == 10'h000)
    else $error("error flags survive status clear");

  brk_hold_a: assert property (
    st_reg.brk_st == usart_cmd_pkg::B_WAIT && !i_tx_idle &&
    !cmd[`C_TX_RST] |=> st_reg.brk_st == usart_cmd_pkg::B_WAIT)
    else $error("break began before transmitter drained");

  brk_mark_a: assert property (
    st_reg.brk_st == usart_cmd_pkg::B_MARK && i_bit_tick &&
    st_reg.bit_cnt == 4'hb && !cmd[`C_TX_RST]
    |=> st_reg.brk_st == usart_cmd_pkg::B_IDLE)
    else $error("mark period not twelve bits");

  to_wait_a: assert property (
    cmd[`C_TO_WAIT] && !cmd[`C_TO_REARM] && !i_rx_char &&
    st_reg.to_st == usart_cmd_pkg::T_WAIT
    |=> !o_timeout && st_reg.to_st == usart_cmd_pkg::T_WAIT)
    else $error("time-out wait did not clear and stall");

  to_fire_a: assert property (
    st_reg.to_st == usart_cmd_pkg::T_RUN && i_bit_tick &&
    st_reg.to_cnt == 17'h0_0001 && st_reg.to_val != 17'h0_0000 &&
    !i_rx_char && !cmd[`C_TO_REARM] |=> o_timeout)
    else $error("time-out flag missed at zero");

  addr_ign_a: assert property (
    cmd[`C_SEND_ADDR] && st_reg.mode[`M_PAR] != `PAR_MULTI &&
    !st_reg.addr_pend |=> !o_addr_bit)
    else $error("address bit set outside multidrop");

  rts_low_a: assert property (
    cmd[`C_RTS_ON] && !cmd[`C_RTS_OFF] && !is_spim |=> !o_rts_n)
    else $error("rts not driven low");

  mode_lock_a: assert property (
    i_wr && i_addr == `OFS_MODE && st_reg.lock |=> $stable(st_reg.mode))
    else $error("locked mode register changed");

  sck_oe_a: assert property (
    o_sck_oe |-> $past(st_reg.mode[`M_CLKSRC]) != `CLK_EXT)
    else $error("clock pin driven with external source");

  nack_lim_a: assert property (
    i_iso_par_err && st_reg.mode[`M_REPEAT_NACK_LIMIT] &&
    st_reg.iter_cnt >= st_reg.mode[`M_MAXIT] |=> !o_nack_send && st_reg.retry)
    else $error("nack sent past the retry limit");

  brk_seq_c: cover property (
    st_reg.brk_st == usart_cmd_pkg::B_STOP ##[1:40]
    st_reg.brk_st == usart_cmd_pkg::B_MARK);
  to_rise_c: cover property ($rose(o_timeout));
  retry_c: cover property ($rose(st_reg.retry));

endmodule

// ### shared/usart_cmd_map.svh
// offsets, field positions, reset values and counts of the command block
`ifndef USART_CMD_MAP_SVH
`define USART_CMD_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_CMD     8'h00
`define OFS_MODE    8'h04
`define OFS_STAT    8'h08
`define OFS_LOCK    8'h0c
`define OFS_TOVAL   8'h10

// ----------------------------------------------------------------
// command strobe bits
// ----------------------------------------------------------------
`define C_RX_RST    2
`define C_TX_RST    3
`define C_RX_EN     4
`define C_RX_DIS    5
`define C_TX_EN     6
`define C_TX_DIS    7
`define C_STAT_CLR  8
`define C_BRK_GO    9
`define C_BRK_END   10
`define C_TO_WAIT   11
`define C_SEND_ADDR 12
`define C_ITER_RST  13
`define C_NACK_CLR  14
`define C_TO_REARM  15
`define C_RTS_ON    18
`define C_RTS_OFF   19
`define C_LIN_ABT   20
`define C_LIN_WAKE  21

// ----------------------------------------------------------------
// mode fields, mask and reset values
// ----------------------------------------------------------------
`define M_PROTO     3:0
`define M_CLKSRC    5:4
`define M_CHAR_LEN_SEL      7:6
`define M_SPI_EDGE_PHASE      8
`define M_PAR       11:9
`define M_STOP      13:12
`define M_LOOP      15:14
`define M_SPI_IDLE_LEVEL      16
`define M_NINE      17
`define M_SERIAL_CLK_DRIVE      18
`define M_OVER      19
`define M_NACK_INHIBIT     20
`define M_REPEAT_NACK_LIMIT    21
`define M_INV       23
`define M_MAXIT     26:24
`define MODE_WMASK  32'h07bf_ffff
`define MODE_RST    32'h0000_0000
`define TOVAL_RST   17'h0_0000

// ----------------------------------------------------------------
// status layout and codes
// ----------------------------------------------------------------
`define ST_RX_ENABLE_CMD     0
`define ST_TX_ENABLE_CMD     1
`define ST_BRK      2
`define ST_TO       3
`define ST_ITER     4
`define ST_NACK     5
`define ST_ADDR     6
`define ST_LOCK     7
`define ST_ERR_LSB  16
`define ERR_TX_MASK 10'h100
`define PAR_MULTI   3'h6
`define CLK_MAIN    2'h0
`define CLK_DIV     2'h1
`define CLK_EXT     2'h3
`define DIV_LAST    3'h7
`define MARK_BITS   4'hc
`define CHAR_XTRA   4'h2

`endif

// ### shared/usart_cmd_pkg.sv
// types of the serial command and mode block
package usart_cmd_pkg;

  typedef enum logic [3:0] {
    P_NORMAL    = 4'h0,
    P_RS485     = 4'h1,
    P_HANDSHAKE = 4'h2,
    P_ISO_T0    = 4'h4,
    P_ISO_T1    = 4'h6,
    P_IRDA      = 4'h8,
    P_LIN_MST   = 4'ha,
    P_LIN_SLV   = 4'hb,
    P_SPI_MST   = 4'he,
    P_SPI_SLV   = 4'hf
  } proto_t;

  typedef enum logic [1:0] {
    L_NORMAL = 2'h0,
    L_ECHO   = 2'h1,
    L_LOCAL  = 2'h2,
    L_REMOTE = 2'h3
  } loop_t;

  typedef enum logic [2:0] {
    B_IDLE = 3'h0,
    B_WAIT = 3'h1,
    B_LOW  = 3'h2,
    B_STOP = 3'h3,
    B_MARK = 3'h4
  } brk_t;

  typedef enum logic [0:0] {
    T_WAIT = 1'h0,
    T_RUN  = 1'h1
  } to_t;

  typedef struct packed {
    logic [2:0] ff;
    logic       val;
  } sync_t;

  typedef struct packed {
    logic [31:0] mode;
    logic [16:0] to_val;
    logic [16:0] to_cnt;
    to_t         to_st;
    logic        to_flag;
    brk_t        brk_st;
    logic [3:0]  bit_cnt;
    logic [9:0]  err;
    logic [2:0]  iter_cnt;
    logic [2:0]  div_cnt;
    logic        sck_prev;
    logic        rx_en;
    logic        tx_en;
    logic        lock;
    logic        retry;
    logic        nack;
    logic        addr_pend;
    logic        rts_lvl;
    logic        cs_force;
    logic        rx_rst;
    logic        tx_rst;
    logic        lin_abort;
    logic        lin_wake;
    logic        nack_send;
    logic        tx_go;
    logic        baud_en;
    logic        rts_n;
    logic        txd;
    logic        rx_line;
    logic        sck;
    logic        sck_oe;
    logic [3:0]  char_bits;
    logic [31:0] rdata;
  } core_t;

endpackage

// ### design/usart_in_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module usart_in_sync (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  // pin side
  input  wire logic i_pin,
  // filtered level
  output logic      o_level
);

  usart_cmd_pkg::sync_t st_reg;
  usart_cmd_pkg::sync_t st_next;

  // first stage feeds only the second; a change counts once 2 and 3 agree
  always_comb begin
    st_next = st_reg;
    st_next.ff = {st_reg.ff[1:0], i_pin};
    if (st_reg.ff[1] == st_reg.ff[2]) begin
      st_next.val = st_reg.ff[2];
    end
  end

  // idle serial lines rest high
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_reg <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_level = st_reg.val;

endmodule

// ### bench/usart_line_peer.sv
// line-side serial peer: receive pin and frame clock
`timescale 1ns/100ps
module usart_line_peer (
  // clock
  input  wire logic i_ref_clk,
  // frame control from the bench
  input  wire logic i_frame,
  input  wire logic i_bit,
  // line pins
  output logic      o_rxd,
  output logic      o_sck
);
  logic sck_q = 1'b0;
  // released line returns to the pull-up level
  assign o_rxd = i_frame ? i_bit : 1'b1;
  assign o_sck = sck_q;
  // clock stands still between frames
  always @(posedge i_ref_clk) begin
    sck_q <= i_frame ? ~sck_q : 1'b0;
  end
endmodule

// ### bench/usart_command_and_mode_control_tb.sv
// self-checking bench of the command and mode block
`timescale 1ns/100ps
module usart_command_and_mode_control_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        tx_idle = 1'b0;
  logic        tick = 1'b0;
  logic        frame = 1'b0;
  logic        bitv = 1'b0;
  logic        zero = 1'b0;
  logic        txs = 1'b1;
  logic        perr = 1'b0;
  logic        soe;
  logic [2:0]  par;
  logic [1:0]  stp;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [9:0]  errs = 10'h000;
  logic [31:0] rdata;
  logic        rxd, sck, txd, rts_n, tmo, rx_en, tx_en;
  logic [3:0]  proto, cbits;
  int          num_errors = 0;
  int          cmp_count = 0;
  logic [3:0]  pr [10] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'ha,
                           4'hb, 4'he, 4'hf};
  usart_line_peer u_peer (.i_ref_clk(clk), .i_frame(frame), .i_bit(bitv),
    .o_rxd(rxd), .o_sck(sck));
  usart_cmd_ctrl u_dut (.i_ref_clk(clk), .i_rst(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rxd(rxd),
    .i_sck(sck), .o_txd(txd), .o_sck(), .o_sck_oe(soe), .o_rts_n(rts_n),
    .i_tx_serial(txs), .i_tx_data_bit(zero), .i_rx_data_bit(zero),
    .i_tx_idle(tx_idle), .i_tx_busy(zero), .i_rx_ready(zero),
    .i_rx_char(zero), .i_bit_tick(tick), .i_baud_clk(zero),
    .i_thr_write(zero), .i_err_events(errs), .i_iso_par_err(perr),
    .i_iso_char_ok(zero), .i_nack_rx(zero), .o_rx_en(rx_en),
    .o_tx_en(tx_en), .o_rx_reset(), .o_tx_reset(), .o_tx_go(),
    .o_addr_bit(), .o_nack_send(), .o_lin_abort(), .o_lin_wake(),
    .o_timeout(tmo), .o_rx_line(), .o_baud_en(), .o_protocol(proto),
    .o_char_bits(cbits), .o_parity(par), .o_stop_bits(stp), .o_sync_spi_edge_phase(),
    .o_spi_idle_level_bit_order_sel(), .o_over8(), .o_invert());
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  // effects are sampled one cycle after the write is taken
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata & m, e);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
    @(posedge clk);
    #1;
  endtask
  task automatic finish_test();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    forever #12.5 clk = ~clk;
  end
  // the whole sequence needs well under a thousand bit ticks
  initial begin
    #(25 * 20000);
    num_errors++;
    finish_test();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({txd, rts_n, cbits}, 6'h35);
    rd_chk(8'h04, 32'hffff_ffff, 32'h0000_0000);
    rd_chk(8'h40, 32'hffff_ffff, 32'h0000_0000);
    wr_reg(8'h00, 32'h0000_0030);
    chk(rx_en, 1'b0);
    wr_reg(8'h00, 32'h0000_0050);
    chk({rx_en, tx_en}, 2'h3);
    wr_reg(8'h00, 32'h0000_00c0);
    chk(tx_en, 1'b0);
    rd_chk(8'h00, 32'hffff_ffff, 32'h0000_0000);
    foreach (pr[i]) begin
      wr_reg(8'h04, {28'h000_0000, pr[i]});
      chk(proto, pr[i]);
    end
    wr_reg(8'h04, 32'h0000_00c0);
    chk(cbits, 4'h8);
    wr_reg(8'h04, 32'hffff_ffff);
    chk(cbits, 4'h9);
    chk({soe, stp}, 3'h3);
    rd_chk(8'h04, 32'hffff_ffff, 32'h07bf_ffff);
    wr_reg(8'h0c, 32'h0000_0001);
    wr_reg(8'h04, 32'h0000_0000);
    rd_chk(8'h04, 32'hffff_ffff, 32'h07bf_ffff);
    wr_reg(8'h0c, 32'h0000_0000);
    wr_reg(8'h04, 32'h0004_0000);
    chk(soe, 1'b1);
    foreach (pr[i]) begin
      if (pr[i] == 4'h0 || pr[i] == 4'he) begin
        wr_reg(8'h04, {28'h000_0000, pr[i]});
        wr_reg(8'h00, 32'h0004_0000);
        chk(rts_n, 1'b0);
        wr_reg(8'h00, 32'h0008_0000);
        chk(rts_n, 1'b1);
      end
    end
    wr_reg(8'h04, 32'h0000_0000);
    @(posedge clk);
    errs <= 10'h3ff;
    @(posedge clk);
    errs <= 10'h000;
    rd_chk(8'h08, 32'h03ff_0000, 32'h03ff_0000);
    wr_reg(8'h00, 32'h0000_0100);
    rd_chk(8'h08, 32'h03ff_0000, 32'h0000_0000);
    wr_reg(8'h04, 32'h0000_0c00);
    chk(par, 3'h6);
    wr_reg(8'h00, 32'h0000_1000);
    rd_chk(8'h08, 32'h0000_0040, 32'h0000_0040);
    wr_reg(8'h00, 32'h0000_0008);
    rd_chk(8'h08, 32'h0000_0040, 32'h0000_0000);
    wr_reg(8'h04, 32'h0000_0000);
    wr_reg(8'h00, 32'h0000_1000);
    rd_chk(8'h08, 32'h0000_0040, 32'h0000_0000);
    // break must wait for an empty transmitter
    wr_reg(8'h00, 32'h0000_0200);
    ticks(2);
    chk(txd, 1'b1);
    @(posedge clk);
    tx_idle <= 1'b1;
    ticks(1);
    chk(txd, 1'b0);
    ticks(6);
    @(posedge clk);
    txs <= 1'b0;
    wr_reg(8'h00, 32'h0000_0400);
    chk(txd, 1'b0);
    @(posedge clk);
    #1;
    chk(txd, 1'b1);
    ticks(11);
    chk(txd, 1'b1);
    ticks(1);
    chk(txd, 1'b0);
    rd_chk(8'h08, 32'h0000_0004, 32'h0000_0000);
    @(posedge clk);
    txs <= 1'b1;
    wr_reg(8'h10, 32'h0000_0003);
    wr_reg(8'h00, 32'h0000_8000);
    ticks(2);
    chk(tmo, 1'b0);
    ticks(1);
    chk(tmo, 1'b1);
    wr_reg(8'h00, 32'h0000_8000);
    wr_reg(8'h00, 32'h0000_0800);
    ticks(4);
    chk(tmo, 1'b0);
    // card mode, limit zero: first parity error raises the retry flag
    wr_reg(8'h04, 32'h0020_0004);
    @(posedge clk);
    perr <= 1'b1;
    @(posedge clk);
    perr <= 1'b0;
    rd_chk(8'h08, 32'h0000_0010, 32'h0000_0010);
    wr_reg(8'h00, 32'h0000_2000);
    rd_chk(8'h08, 32'h0000_0010, 32'h0000_0000);
    // remote loopback copies the receive pin to the transmit pin
    wr_reg(8'h04, 32'h0000_c000);
    @(posedge clk);
    frame <= 1'b1;
    ticks(4);
    chk(txd, 1'b0);
    frame <= 1'b0;
    ticks(4);
    chk(txd, 1'b1);
    finish_test();
  end
endmodule
